/* hdl/afe_cfg_pkg.sv */
// constants and types shared by the front-end configuration register bank
// Functional notes
// R1: sixteen-bit offset split low/high bytes, reset zero
// R2: setup wait is field times 40 clocks
// R3: bit5 zero enables high-pass filter, one bypasses
// R4: gain bit set shifts decimator output left two
// R5: rf decimator 00 bypass, 01 low, 1x high
// R6: bit1 zero runs baseband decimator, one bypasses
// R7: bit0 zero runs demodulator, one passes through
// R8: chip addressing mode bit, off at reset
// R9: in mode, accept only when qualifier equals straps
// R10: qualifier read returns live strap pin levels
// R11: signed offset added to every channel sample
`default_nettype none
package afe_cfg_pkg;
  // register addresses on the internal register port
  localparam logic [12:0] ADDR_OFFSET_LOW  = 13'h0110;
  localparam logic [12:0] ADDR_OFFSET_HIGH = 13'h0111;
  localparam logic [12:0] ADDR_POWER_SETUP = 13'h0112;
  localparam logic [12:0] ADDR_STAGE_CFG   = 13'h0113;
  localparam logic [12:0] ADDR_CHIP_QUAL   = 13'h0115;
  localparam logic [12:0] ADDR_TONE_CTRL   = 13'h0116;
  // reset values
  localparam logic [7:0] RST_OFFSET_LOW  = 8'h00;
  localparam logic [7:0] RST_OFFSET_HIGH = 8'h00;
  localparam logic [4:0] RST_POWER_SETUP = 5'h02;
  localparam logic [7:0] RST_STAGE_CFG   = 8'h00;
  localparam logic       RST_CHIP_MODE   = 1'b0;
  localparam logic [4:0] RST_CHIP_QUAL   = 5'h00;
  localparam logic [7:0] RST_TONE_CTRL   = 8'h00;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;
  // field positions inside processing_stage_config
  localparam int BIT_HPF_BYPASS  = 5;
  localparam int BIT_GAIN_SCALE  = 4;
  localparam int BIT_RF_DEC_HI   = 3;
  localparam int BIT_RF_DEC_LO   = 2;
  localparam int BIT_BB_BYPASS   = 1;
  localparam int BIT_DEMOD_BYPASS = 0;
  // mode bit position inside chip_qualify_control, then power setup and strap field widths
  localparam int BIT_CHIP_MODE   = 5;
  localparam int POWER_FIELD_W   = 5;
  localparam int STRAP_W         = 5;
  // setup time unit, in sample clock periods
  localparam int SETUP_UNIT_CLOCKS = 40;
  localparam int SETUP_MAX_CLOCKS  = 31 * SETUP_UNIT_CLOCKS;
  localparam int SETUP_CNT_W       = $clog2(SETUP_MAX_CLOCKS + 1);
  localparam int GAIN_SHIFT        = 2;

  // decoded stage controls handed to the datapath
  typedef struct packed {
    logic hpf_enable;
    logic gain_scale;
    logic rf_dec_enable;
    logic rf_dec_high_band;
    logic bb_dec_enable;
    logic demod_enable;
  } stage_ctrl_s;

  // power-up sequencer states, one-hot
  typedef enum logic [2:0] {
    PWR_IDLE  = 3'b001,
    PWR_WAIT  = 3'b010,
    PWR_READY = 3'b100
  } pwr_state_e;
endpackage : afe_cfg_pkg
`default_nettype wire

/* hdl/afe_digital_config_regs.sv */
// configuration register bank with stage decode, power setup timer and offset adders
`timescale 1ns/1ns
`default_nettype none
module afe_digital_config_regs
  import afe_cfg_pkg::*;
#(
  parameter int NUM_CH   = 8,   // receive channels
  parameter int SAMPLE_W = 16   // sample width
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  input  wire logic [12:0]                reg_addr,        // register address from serial port
  input  wire logic [7:0]                 reg_wdata,       // write byte
  input  wire logic                       reg_wr,          // write strobe, one cycle
  input  wire logic                       reg_rd,          // read strobe, one cycle
  output logic      [7:0]                 reg_rdata,       // read byte
  output logic                            reg_rvalid,      // read answer pulse
  output logic                            access_ok,       // chip selected by qualifier
  input  wire logic [STRAP_W-1:0]         strap_pin,       // address strap pins
  input  wire logic                       power_up_req,    // start of power-up, pulse
  output logic                            power_ready,     // setup time elapsed
  output stage_ctrl_s                     stage_ctrl,      // decoded processing controls
  output logic      [7:0]                 tone_ctrl,       // analog tone byte, stored only
  input  wire logic [SAMPLE_W-1:0]        dec_in,          // decimator output
  output logic      [SAMPLE_W-1:0]        dec_out,         // decimator output after gain
  input  wire logic [NUM_CH*SAMPLE_W-1:0] sample_in,       // raw channel samples
  output logic      [NUM_CH*SAMPLE_W-1:0] sample_out       // offset corrected samples
);

  logic [7:0]               offset_low;     // offset correction bits 7..0
  logic [7:0]               offset_high;    // offset correction bits 15..8
  logic [POWER_FIELD_W-1:0] power_setup;    // setup time in units of 40 clocks
  logic [7:0]               stage_cfg;      // processing stage byte
  logic                     chip_mode;      // chip addressing mode
  logic [STRAP_W-1:0]       chip_qual;      // written qualifier
  logic                     wr_ok;          // qualified write
  pwr_state_e               pwr_state;      // power sequencer state
  logic [SETUP_CNT_W-1:0]   setup_cnt;      // remaining wait clocks
  logic [SETUP_CNT_W-1:0]   setup_load;     // wait length from the field
  logic signed [15:0]       offset_val;     // combined signed offset

  // qualification: mode off accepts everything
  assign access_ok = !chip_mode || (chip_qual == strap_pin); // R8 R9
  assign wr_ok     = reg_wr && access_ok;

  // offset correction byte registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      offset_low  <= RST_OFFSET_LOW;  // R1
      offset_high <= RST_OFFSET_HIGH; // R1
    end else if (wr_ok) begin
      if (reg_addr == ADDR_OFFSET_LOW) begin
        offset_low <= reg_wdata; // R1
      end
      if (reg_addr == ADDR_OFFSET_HIGH) begin
        offset_high <= reg_wdata; // R1
      end
    end
  end

  // power setup field, upper three bits ignored
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_setup <= RST_POWER_SETUP; // R2
    end else if (wr_ok && reg_addr == ADDR_POWER_SETUP) begin
      power_setup <= reg_wdata[POWER_FIELD_W-1:0]; // R2
    end
  end

  // processing stage byte and tone byte
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_cfg <= RST_STAGE_CFG;
      tone_ctrl <= RST_TONE_CTRL;
    end else if (wr_ok) begin
      if (reg_addr == ADDR_STAGE_CFG) begin
        stage_cfg <= reg_wdata;
      end
      if (reg_addr == ADDR_TONE_CTRL) begin
        tone_ctrl <= reg_wdata;
      end
    end
  end

  // chip addressing: a write here is itself qualified by the old setting
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      chip_mode <= RST_CHIP_MODE; // R8
      chip_qual <= RST_CHIP_QUAL; // R9
    end else if (wr_ok && reg_addr == ADDR_CHIP_QUAL) begin
      chip_mode <= reg_wdata[BIT_CHIP_MODE];  // R8
      chip_qual <= reg_wdata[STRAP_W-1:0];    // R9
    end
  end

  // read mux, registered; unqualified reads answer zero so the bus stays defined
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= READ_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (!access_ok) begin
          reg_rdata <= READ_UNMAPPED; // R9
        end else begin
          unique case (reg_addr)
            ADDR_OFFSET_LOW:  reg_rdata <= offset_low;
            ADDR_OFFSET_HIGH: reg_rdata <= offset_high;
            ADDR_POWER_SETUP: reg_rdata <= {3'h0, power_setup};
            ADDR_STAGE_CFG:   reg_rdata <= stage_cfg;
            ADDR_CHIP_QUAL:   reg_rdata <= {2'h0, chip_mode, strap_pin}; // R10
            ADDR_TONE_CTRL:   reg_rdata <= tone_ctrl;
            default:          reg_rdata <= READ_UNMAPPED;
          endcase
        end
      end
    end
  end

  // stage decode, zero means the stage runs for the high-pass, baseband and demodulator bits
  always_comb begin
    stage_ctrl.hpf_enable       = !stage_cfg[BIT_HPF_BYPASS];   // R3
    stage_ctrl.gain_scale       = stage_cfg[BIT_GAIN_SCALE];    // R4
    stage_ctrl.rf_dec_enable    = stage_cfg[BIT_RF_DEC_HI] || stage_cfg[BIT_RF_DEC_LO]; // R5
    stage_ctrl.rf_dec_high_band = stage_cfg[BIT_RF_DEC_HI];     // R5
    stage_ctrl.bb_dec_enable    = !stage_cfg[BIT_BB_BYPASS];    // R6
    stage_ctrl.demod_enable     = !stage_cfg[BIT_DEMOD_BYPASS]; // R7
  end

  // decimator gain, plain shift so overflow wraps like the datapath it feeds
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_out <= '0;
    end else if (stage_ctrl.gain_scale) begin
      dec_out <= dec_in << GAIN_SHIFT; // R4
    end else begin
      dec_out <= dec_in; // R4
    end
  end

  // wait length; product fits the counter width by construction
  assign setup_load = SETUP_CNT_W'(power_setup * SETUP_UNIT_CLOCKS); // R2

  // power-up sequencer: new request restarts the wait
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_state <= PWR_IDLE;
      setup_cnt <= '0;
    end else if (power_up_req) begin
      pwr_state <= (setup_load == '0) ? PWR_READY : PWR_WAIT; // R2
      setup_cnt <= setup_load;
    end else begin
      unique case (pwr_state)
        PWR_IDLE:  pwr_state <= PWR_IDLE;
        PWR_WAIT: begin
          // last wait clock moves to ready
          if (setup_cnt == SETUP_CNT_W'(1)) begin
            pwr_state <= PWR_READY; // R2
          end
          setup_cnt <= setup_cnt - SETUP_CNT_W'(1);
        end
        PWR_READY: pwr_state <= PWR_READY;
        default:   pwr_state <= PWR_IDLE;
      endcase
    end
  end
  assign power_ready = (pwr_state == PWR_READY);

  // per-channel offset adders, saturating to avoid wrap at full scale
  assign offset_val = {offset_high, offset_low};
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic signed [SAMPLE_W:0] sum; // one guard bit
      assign sum = $signed({sample_in[ch*SAMPLE_W+SAMPLE_W-1], sample_in[ch*SAMPLE_W +: SAMPLE_W]})
                 + $signed({offset_val[15], offset_val}); // R11
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          sample_out[ch*SAMPLE_W +: SAMPLE_W] <= '0;
        end else if (sum[SAMPLE_W] != sum[SAMPLE_W-1]) begin
          // clip to the rail of the sign
          sample_out[ch*SAMPLE_W +: SAMPLE_W] <= {sum[SAMPLE_W], {(SAMPLE_W-1){!sum[SAMPLE_W]}}};
        end else begin
          sample_out[ch*SAMPLE_W +: SAMPLE_W] <= sum[SAMPLE_W-1:0]; // R11
        end
      end
    end
  endgenerate

  // checks
  offset_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R1
    wr_ok && reg_addr == ADDR_OFFSET_HIGH |=> offset_val[15:8] == $past(reg_wdata))
    else $error("offset high byte not stored");
  // any non-zero field waits at least 40 clocks, so ready is low 8 clocks on
  setup_length_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R2
    power_up_req && power_setup != 5'h00 ##1 !power_up_req [*8] |-> !power_ready)
    else $error("power ready too early");
  setup_done_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R2
    power_up_req && power_setup == 5'h01 ##1 !power_up_req [*8] |-> ##[1:40] power_ready)
    else $error("power ready late");
  // decode checked against the written byte, not against the register copy
  hpf_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R3
    wr_ok && reg_addr == ADDR_STAGE_CFG |=> stage_ctrl.hpf_enable == !$past(reg_wdata[5]))
    else $error("high-pass decode wrong");
  gain_shift_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R4
    $past(stage_ctrl.gain_scale) |-> dec_out == SAMPLE_W'($past(dec_in) * 4))
    else $error("decimator gain wrong");
  rf_code_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R5
    wr_ok && reg_addr == ADDR_STAGE_CFG |=>
      stage_ctrl.rf_dec_enable == ($past(reg_wdata[3:2]) != 2'b00) &&
      stage_ctrl.rf_dec_high_band == $past(reg_wdata[3]))
    else $error("rf decimator decode wrong");
  bypass_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6 R7
    wr_ok && reg_addr == ADDR_STAGE_CFG |=>
      stage_ctrl.bb_dec_enable == !$past(reg_wdata[1]) &&
      stage_ctrl.demod_enable == !$past(reg_wdata[0]))
    else $error("bypass decode wrong");
  qualify_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R8 R9
    reg_wr && chip_mode && chip_qual != strap_pin |=> $stable(stage_cfg) && $stable(tone_ctrl))
    else $error("unqualified write took effect");
  strap_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R10
    reg_rd && access_ok && reg_addr == ADDR_CHIP_QUAL |=> reg_rdata[4:0] == $past(strap_pin))
    else $error("qualifier read not strap levels");
  offset_sum_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
    offset_val == 16'h0000 |=> sample_out == $past(sample_in))
    else $error("zero offset altered samples");
  write_cov: cover property (@(posedge sys_clk) disable iff (!rst_b)
    wr_ok && reg_addr == ADDR_STAGE_CFG);
  ready_cov: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(power_ready));
  refuse_cov: cover property (@(posedge sys_clk) disable iff (!rst_b) reg_wr && !access_ok);
endmodule : afe_digital_config_regs
`default_nettype wire

/* test/afe_host_model.sv */
// host-side model of the register port that feeds the configuration bank
`timescale 1ns/1ns
`default_nettype none
module afe_host_model (
  input  wire logic        sys_clk,
  output logic      [12:0] reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic        reg_rvalid
);
  // idle port from time zero
  initial begin
    reg_addr  = 13'h0000;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // one write, strobe held across exactly one edge
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge sys_clk) #1;
    reg_wr    = 1'b0;
    // released lines flip so stale values cannot pass for good ones
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr
  // one read; ok stays low if no answer comes within four cycles
  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge sys_clk) #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    // answer is a one-cycle pulse, looked at right after each edge
    for (int i = 0; i < 4 && !ok; i++) begin
      if (reg_rvalid === 1'b1) begin
        d  = reg_rdata;
        ok = 1'b1;
      end
      else @(posedge sys_clk) #1;
    end
  endtask : rd
endmodule : afe_host_model
`default_nettype wire

/* test/test_afe_digital_config_regs.sv */
// self-checking bench for the front-end configuration register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_afe_digital_config_regs;
  import afe_cfg_pkg::*;
  logic         sys_clk = 1'b0;
  logic         rst_b, reg_wr, reg_rd, reg_rvalid, access_ok, power_up_req, power_ready, ok;
  logic [12:0]  reg_addr;
  logic [7:0]   reg_wdata, reg_rdata, tone_ctrl, d;
  logic [4:0]   strap_pin;
  logic [15:0]  dec_in, dec_out;
  logic [127:0] sample_in, sample_out;
  stage_ctrl_s  stage_ctrl;
  int           n_errors = 0, checks = 0, n;
  // rows: address, reset readback, write byte, readback after write
  localparam logic [36:0] rows [7] = '{
    {13'h110, 8'h00, 8'ha5, 8'ha5}, {13'h111, 8'h00, 8'h5a, 8'h5a},
    {13'h112, 8'h02, 8'hff, 8'h1f}, {13'h113, 8'h00, 8'h3f, 8'h3f},
    {13'h115, 8'h0a, 8'h13, 8'h0a}, {13'h116, 8'h00, 8'hc3, 8'hc3},
    {13'h114, 8'h00, 8'hff, 8'h00}};
  localparam int pf [3] = '{0, 31, 1};  // zero first: ready is still low then
  // 250 MHz sample clock
  always #2 sys_clk = ~sys_clk;
  afe_digital_config_regs i_afe_digital_config_regs (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .access_ok(access_ok), .strap_pin(strap_pin), .power_up_req(power_up_req),
    .power_ready(power_ready), .stage_ctrl(stage_ctrl), .tone_ctrl(tone_ctrl),
    .dec_in(dec_in), .dec_out(dec_out), .sample_in(sample_in), .sample_out(sample_out));
  afe_host_model i_afe_host_model (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  // report counts, give the verdict, stop
  task finish_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // read and compare; a missing answer ends the run
  task rdchk(input logic [12:0] a, input logic [7:0] e);
    i_afe_host_model.rd(a, d, ok);
    if (!ok) begin
      n_errors++;
      finish_test();
    end
    `CHK(d, e)
  endtask : rdchk
  // main sequence
  initial begin
    rst_b = 1'b0;
    strap_pin = 5'h0a;
    power_up_req = 1'b0;
    dec_in = 16'h1234;
    sample_in = {8{16'h0001}};
    repeat (10) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    // reset values, then write and read back every row
    foreach (rows[k]) rdchk(rows[k][36:24], rows[k][23:16]);
    foreach (rows[k]) begin
      i_afe_host_model.wr(rows[k][36:24], rows[k][15:8]);
      rdchk(rows[k][36:24], rows[k][7:0]);
    end
    // every processing code, decode and gain path
    for (int v = 0; v < 64; v++) begin
      i_afe_host_model.wr(ADDR_STAGE_CFG, v[7:0]);
      `CHK(stage_ctrl, {~v[5], v[4], |v[3:2], v[3], ~v[1], ~v[0]})
      #4 `CHK(dec_out, v[4] ? 16'h48d0 : 16'h1234)
    end
    // offset 0x5aa5 added per channel, then a saturating case on channel 0
    `CHK(sample_out, {8{16'h5aa6}})
    i_afe_host_model.wr(ADDR_OFFSET_HIGH, 8'h7f);
    sample_in = {{7{16'h0001}}, 16'h7000};
    #4 `CHK(sample_out, {{7{16'h7fa6}}, 16'h7fff})
    // setup wait is field times 40 clocks, zero is ready at the request edge
    foreach (pf[k]) begin
      i_afe_host_model.wr(ADDR_POWER_SETUP, 8'(pf[k]));
      power_up_req = 1'b1;
      @(posedge sys_clk) #1;
      power_up_req = 1'b0;
      n = 0;
      while (power_ready !== 1'b1 && n < 2000) begin
        @(posedge sys_clk) #1;
        n++;
      end
      `CHK(n, pf[k] * 40)
      if (n == 2000) finish_test();
    end
    // chip addressing: matching straps pass, mismatch locks writes out
    i_afe_host_model.wr(ADDR_CHIP_QUAL, 8'h2a);
    `CHK(access_ok, 1'b1)
    rdchk(ADDR_CHIP_QUAL, 8'h2a);
    strap_pin = 5'h0b;
    #1 `CHK(access_ok, 1'b0)
    i_afe_host_model.wr(ADDR_TONE_CTRL, 8'h77);
    rdchk(ADDR_OFFSET_LOW, 8'h00);
    strap_pin = 5'h0a;
    rdchk(ADDR_TONE_CTRL, 8'hc3);
    `CHK(tone_ctrl, 8'hc3)
    // second reset in mid-run
    rst_b = 1'b0;
    #1 `CHK(stage_ctrl, 6'b100011)
    `CHK(power_ready, 1'b0)
    `CHK(access_ok, 1'b1)
    `CHK(sample_out, 128'h0)
    `CHK(dec_out, 16'h0000)
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    rdchk(ADDR_OFFSET_HIGH, 8'h00);
    rdchk(ADDR_POWER_SETUP, 8'h02);
    finish_test();
  end
endmodule : test_afe_digital_config_regs
`default_nettype wire
